// [design/upsc_tick.sv]
`timescale 1ns/10ps
module upsc_tick
	import upsc_pkg::*;
#(
	parameter int FRAME_CYCLES = UPSC_FRAME_CYC,
	parameter int MS_CYCLES = UPSC_MS_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	output logic frame_tick,
	output logic ms_tick
);
	typedef struct packed {
		logic [31:0] fr_cnt;
		logic [31:0] ms_cnt;
		logic fr;
		logic ms;
	} upsc_tick_st_t;

	upsc_tick_st_t r_reg;
	upsc_tick_st_t r_next;

	// Free-running frame and millisecond dividers
	always_comb
	begin
		r_next = r_reg;
		r_next.fr = 1'h0;
		r_next.ms = 1'h0;
		if (r_reg.fr_cnt >= 32'(FRAME_CYCLES - 1))
		begin
			r_next.fr_cnt = 32'h0;
			r_next.fr = 1'h1;
		end
		else
			r_next.fr_cnt = r_reg.fr_cnt + 32'h1;
		if (r_reg.ms_cnt >= 32'(MS_CYCLES - 1))
		begin
			r_next.ms_cnt = 32'h0;
			r_next.ms = 1'h1;
		end
		else
			r_next.ms_cnt = r_reg.ms_cnt + 32'h1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign frame_tick = r_reg.fr;
	assign ms_tick = r_reg.ms;
endmodule

// [design/upsc_top.sv]
// Function
// R01 - Setting 1 command disables port at once
// R02 - Setting 1 timeout 40..65000 frames, default 2000
// R03 - Each received character reloads inactivity timer
// R04 - No timeout right after setting 1 applied
// R05 - Own pending output enables port, blocks idle
// R06 - 2G: enable with paging after 2.0 s
// R07 - 3G: on 20 ms, off 2.5 s, repeat
// R08 - Unregistered: on 20 ms, off 2.5 s
// R09 - With flow control, CTS shows port enable
// R10 - Setting 2 refused with flow control enabled
// R11 - Setting 2: RTS off disables port
// R12 - Setting 2: RTS on enables, active 20 ms later
// R13 - Setting 2: RTS on keeps port, no idle
// R14 - Setting 3 works with any flow control
// R15 - Setting 3: DTR off disables port
// R16 - Setting 3: DTR on enables, active 20 ms later
// R17 - Setting 3: DTR on holds port; DTR passthrough
// R18 - TXD rise wakes in 20 ms, discards character
// R19 - Data wake only setting 1 without flow control
// R20 - Host waits 20 ms after wake character
// R21 - Host sends extra leading character with autobaud
// R22 - Host sends dummy attention without autobaud
// R23 - USB active forbids idle, port still governed
// R24 - Setting 0: never idle, CTS on after init
// R25 - All timing from one free-running tick source
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module upsc_top
	import upsc_pkg::*;
#(
	parameter int FRAME_CYCLES = UPSC_FRAME_CYC,
	parameter int MS_CYCLES = UPSC_MS_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic host_txd,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic usb_active,
	input wire logic port_init_done,
	input wire logic tx_pending,
	input wire logic rx_char,
	input wire logic paging_rx,
	output logic cts_n,
	output logic port_en,
	output logic idle_ok,
	output logic waking,
	output logic dtr_ctrl
);
	typedef struct packed {
		upsc_setting_t set;
		logic hwfc;
		logic [15:0] tmo;
		logic [1:0] net;
		logic reject;
		upsc_state_t st;
		logic [11:0] ms_cnt;
		logic [15:0] fr_cnt;
		logic txd_prev;
		logic port_en;
		logic idle_ok;
		logic waking;
		logic cts_n;
		logic dtr_ctrl;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} upsc_st_t;

	upsc_st_t r_reg;
	upsc_st_t r_next;
	logic frame_tick;
	logic ms_tick;

	// Register view of the current state
	function automatic logic [31:0] reg_read(
		input upsc_st_t s,
		input logic [7:0] addr
	);
		logic [31:0] v;
		v = 32'h0;
		unique case (addr)
			UPSC_OFS_CTRL:
			begin
				v[1:0] = s.set;
				v[UPSC_CTRL_HWFC_BIT] = s.hwfc;
			end
			UPSC_OFS_TMO: v[15:0] = s.tmo;
			UPSC_OFS_NET: v[1:0] = s.net;
			UPSC_OFS_STAT:
			begin
				v[UPSC_STAT_CTS_BIT] = ~s.cts_n;
				v[UPSC_STAT_PORT_BIT] = s.port_en;
				v[UPSC_STAT_IDLE_BIT] = s.idle_ok;
				v[UPSC_STAT_WAKE_BIT] = s.waking;
				v[UPSC_STAT_REJ_BIT] = s.reject;
			end
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic logic addr_mapped(input logic [7:0] addr);
		return addr == UPSC_OFS_CTRL || addr == UPSC_OFS_TMO ||
			addr == UPSC_OFS_NET || addr == UPSC_OFS_STAT;
	endfunction

	// Shared frame and millisecond time base
	upsc_tick #(
		.FRAME_CYCLES(FRAME_CYCLES),
		.MS_CYCLES(MS_CYCLES)
	) u_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.frame_tick(frame_tick), // R25
		.ms_tick(ms_tick) // R25
	);

	always_comb
	begin
		logic line_on;
		logic txd_rise;
		logic wod_arm;
		logic [31:0] wv;
		upsc_setting_t ws;
		logic wh;
		line_on = (r_reg.set == UPSC_SET_RTS) ? ~rts_n : ~dtr_n;
		txd_rise = host_txd & ~r_reg.txd_prev;
		wod_arm = (r_reg.set == UPSC_SET_CYCLIC) && !r_reg.hwfc; // R19
		wv = 32'h0;
		ws = UPSC_SET_FIXED;
		wh = 1'h0;
		r_next = r_reg;
		r_next.txd_prev = host_txd;
		r_next.dtr_ctrl = ~dtr_n; // R17
		if (ms_tick && r_reg.ms_cnt != UPSC_MS_SAT)
			r_next.ms_cnt = r_reg.ms_cnt + 12'h001;

		// Power-save sequencing
		unique case (r_reg.set)
			UPSC_SET_FIXED: r_next.st = UPSC_ST_ON; // R24
			UPSC_SET_CYCLIC:
			begin
				unique case (r_reg.st)
					UPSC_ST_OFF:
					begin
						if (wod_arm && txd_rise)
						begin
							r_next.st = UPSC_ST_WAKE; // R18
							r_next.ms_cnt = 12'h000;
						end
						else if (r_reg.net == UPSC_NET_2G)
						begin
							if (paging_rx && r_reg.ms_cnt >= UPSC_OFF_2G_MS)
							begin
								r_next.st = UPSC_ST_WIN; // R06
								r_next.ms_cnt = 12'h000;
							end
						end
						else if (r_reg.ms_cnt >= UPSC_OFF_3G_MS)
						begin
							r_next.st = UPSC_ST_WIN; // R07 R08
							r_next.ms_cnt = 12'h000;
						end
					end
					UPSC_ST_WIN:
					begin
						if (rx_char)
						begin
							r_next.st = UPSC_ST_ACT;
							r_next.fr_cnt = r_reg.tmo; // R03
						end
						else if (r_reg.ms_cnt >= UPSC_WIN_MS)
						begin
							r_next.st = UPSC_ST_OFF; // R07 R08
							r_next.ms_cnt = 12'h000;
						end
					end
					UPSC_ST_ACT:
					begin
						if (rx_char)
							r_next.fr_cnt = r_reg.tmo; // R03
						else if (frame_tick)
						begin
							if (r_reg.fr_cnt <= 16'h0001)
							begin
								r_next.st = UPSC_ST_OFF; // R02
								r_next.ms_cnt = 12'h000;
							end
							else
								r_next.fr_cnt = r_reg.fr_cnt - 16'h0001;
						end
					end
					UPSC_ST_WAKE:
					begin
						if (r_reg.ms_cnt >= UPSC_WAKE_MS)
						begin
							r_next.st = UPSC_ST_ACT; // R18
							r_next.fr_cnt = r_reg.tmo;
						end
					end
					default:
					begin
						r_next.st = UPSC_ST_OFF;
						r_next.ms_cnt = 12'h000;
					end
				endcase
			end
			UPSC_SET_RTS, UPSC_SET_DTR:
			begin
				if (!line_on)
					r_next.st = UPSC_ST_OFF; // R11 R15
				else if (r_reg.st == UPSC_ST_OFF)
				begin
					r_next.ms_cnt = 12'h000;
					// Wake delay only when coming out of idle
					r_next.st = r_reg.idle_ok ? UPSC_ST_WAKE : UPSC_ST_ON; // R12 R16
				end
				else if (r_reg.st == UPSC_ST_WAKE)
				begin
					if (r_reg.ms_cnt >= UPSC_WAKE_MS)
						r_next.st = UPSC_ST_ON; // R12 R16
				end
				else
					r_next.st = UPSC_ST_ON; // R13 R17
			end
		endcase

		// Register bus: write channels
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'h0;
		if (s_axi_awvalid && r_reg.awready)
		begin
			r_next.aw_full = 1'h1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready)
		begin
			r_next.w_full = 1'h1;
			r_next.w_data = s_axi_wdata;
			r_next.w_strb = s_axi_wstrb;
		end
		if (r_next.aw_full && r_next.w_full)
		begin
			r_next.aw_full = 1'h0;
			r_next.w_full = 1'h0;
			r_next.bvalid = 1'h1;
			r_next.bresp = addr_mapped(r_next.aw_addr) ? UPSC_RESP_OKAY :
				UPSC_RESP_SLVERR;
			wv = lane_merge(reg_read(r_reg, r_next.aw_addr), r_next.w_data,
				r_next.w_strb);
			unique case (r_next.aw_addr)
				UPSC_OFS_CTRL:
				begin
					ws = upsc_setting_t'(wv[1:0]);
					wh = wv[UPSC_CTRL_HWFC_BIT];
					if (ws == UPSC_SET_RTS && wh)
						r_next.reject = 1'h1; // R10
					else
					begin
						r_next.reject = 1'h0; // R14
						r_next.set = ws;
						r_next.hwfc = wh;
						if (ws == UPSC_SET_CYCLIC)
						begin
							r_next.st = UPSC_ST_OFF; // R01 R04
							r_next.ms_cnt = 12'h000;
						end
					end
				end
				UPSC_OFS_TMO:
				begin
					if (wv[15:0] >= UPSC_TMO_MIN && wv[15:0] <= UPSC_TMO_MAX)
					begin
						r_next.tmo = wv[15:0]; // R02
						r_next.reject = 1'h0;
					end
					else
						r_next.reject = 1'h1; // R02
				end
				UPSC_OFS_NET: r_next.net = wv[1:0];
				default: r_next.reject = r_reg.reject;
			endcase
		end
		r_next.awready = !r_next.aw_full && !r_next.bvalid;
		r_next.wready = !r_next.w_full && !r_next.bvalid;

		// Register bus: read channel
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'h0;
		if (s_axi_arvalid && r_reg.arready)
		begin
			r_next.rvalid = 1'h1;
			r_next.rdata = reg_read(r_reg, s_axi_araddr);
			r_next.rresp = addr_mapped(s_axi_araddr) ? UPSC_RESP_OKAY :
				UPSC_RESP_SLVERR;
		end
		r_next.arready = !r_next.rvalid;

		// Pin outputs
		r_next.port_en = r_next.st == UPSC_ST_ON || r_next.st == UPSC_ST_WIN ||
			r_next.st == UPSC_ST_ACT || tx_pending || // R05
			(r_next.st == UPSC_ST_WAKE && r_next.set != UPSC_SET_CYCLIC);
		r_next.idle_ok = r_next.set != UPSC_SET_FIXED && // R24
			r_next.st == UPSC_ST_OFF && !tx_pending && // R05
			!usb_active; // R23
		r_next.waking = r_next.st == UPSC_ST_WAKE; // R18
		if (r_next.hwfc && (r_next.set == UPSC_SET_CYCLIC ||
			r_next.set == UPSC_SET_DTR))
			r_next.cts_n = ~r_next.port_en; // R09
		else
			r_next.cts_n = ~port_init_done; // R24
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r_reg <= '0;
			r_reg.set <= UPSC_SET_FIXED;
			r_reg.hwfc <= UPSC_HWFC_RST;
			r_reg.tmo <= UPSC_TMO_RST; // R02
			r_reg.net <= UPSC_NET_RST;
			r_reg.st <= UPSC_ST_ON;
			r_reg.cts_n <= 1'h1;
			// Idle line level, so release gives no false wake edge
			r_reg.txd_prev <= 1'h1;
		end
		else
			r_reg <= r_next;
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready = r_reg.wready;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign cts_n = r_reg.cts_n;
	assign port_en = r_reg.port_en;
	assign idle_ok = r_reg.idle_ok;
	assign waking = r_reg.waking;
	assign dtr_ctrl = r_reg.dtr_ctrl;
endmodule

// [shared/upsc_pkg.sv]
package upsc_pkg;
	// Clock and time base
	localparam int UPSC_CLK_NS = 40;
	localparam int UPSC_FRAME_NS = 4615000;
	localparam int UPSC_MS_NS = 1000000;
	localparam int UPSC_FRAME_CYC = UPSC_FRAME_NS / UPSC_CLK_NS;
	localparam int UPSC_MS_CYC = UPSC_MS_NS / UPSC_CLK_NS;
	// Millisecond durations
	localparam logic [11:0] UPSC_WIN_MS = 12'h014;
	localparam logic [11:0] UPSC_WAKE_MS = 12'h014;
	localparam logic [11:0] UPSC_OFF_2G_MS = 12'h7d0;
	localparam logic [11:0] UPSC_OFF_3G_MS = 12'h9c4;
	localparam logic [11:0] UPSC_MS_SAT = 12'hfff;
	// Inactivity timeout in frames
	localparam logic [15:0] UPSC_TMO_MIN = 16'h0028;
	localparam logic [15:0] UPSC_TMO_MAX = 16'hfde8;
	localparam logic [15:0] UPSC_TMO_RST = 16'h07d0;
	// Register byte offsets
	localparam logic [7:0] UPSC_OFS_CTRL = 8'h00;
	localparam logic [7:0] UPSC_OFS_TMO = 8'h04;
	localparam logic [7:0] UPSC_OFS_NET = 8'h08;
	localparam logic [7:0] UPSC_OFS_STAT = 8'h0c;
	// Field positions
	localparam int UPSC_CTRL_HWFC_BIT = 2;
	localparam int UPSC_STAT_CTS_BIT = 0;
	localparam int UPSC_STAT_PORT_BIT = 1;
	localparam int UPSC_STAT_IDLE_BIT = 2;
	localparam int UPSC_STAT_WAKE_BIT = 3;
	localparam int UPSC_STAT_REJ_BIT = 4;
	// Reset values
	localparam logic UPSC_HWFC_RST = 1'h1;
	localparam logic [1:0] UPSC_NET_RST = 2'h0;
	// Network registration codes
	localparam logic [1:0] UPSC_NET_NONE = 2'h0;
	localparam logic [1:0] UPSC_NET_2G = 2'h1;
	localparam logic [1:0] UPSC_NET_3G = 2'h2;
	// Bus responses
	localparam logic [1:0] UPSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] UPSC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		UPSC_SET_FIXED,
		UPSC_SET_CYCLIC,
		UPSC_SET_RTS,
		UPSC_SET_DTR
	} upsc_setting_t;

	typedef enum logic [2:0] {
		UPSC_ST_ON,
		UPSC_ST_OFF,
		UPSC_ST_WIN,
		UPSC_ST_ACT,
		UPSC_ST_WAKE
	} upsc_state_t;
endpackage

// [tb/uart_power_save_control_tb_top.sv]
`timescale 1ns/10ps
module uart_power_save_control_tb_top;
	import upsc_pkg::*;
	localparam int MSC = 4;
	logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, usb_active, port_init_done;
	logic tx_pending, rx_char, paging_rx, wake_req, rts_on, dtr_on;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, host_txd, rts_n, dtr_n, cts_n, port_en;
	logic idle_ok, waking, dtr_ctrl, busy;
	logic [31:0] tv [4] = '{32'h27, 32'hfde8, 32'hfde9, 32'h28};
	logic [31:0] rv [4] = '{32'h13, 32'h03, 32'h13, 32'h03};
	int error_cnt, checks, cyc;
	upsc_top #(.FRAME_CYCLES(20), .MS_CYCLES(MSC)) u_dut (.clk, .sys_rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .host_txd, .rts_n, .dtr_n, .usb_active,
		.port_init_done, .tx_pending, .rx_char, .paging_rx, .cts_n,
		.port_en, .idle_ok, .waking, .dtr_ctrl);
	upsc_host #(.MS_CYCLES(MSC)) u_host (.clk, .sys_rst, .wake_req,
		.rts_on, .dtr_on, .host_txd, .rts_n, .dtr_n, .busy);
	always #20 clk = !clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			error_cnt++;
			test_done;
		end
	end
	task automatic test_done;
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_port(input logic v, input int n);
		int i;
		i = 0;
		while (port_en !== v && i < n)
		begin
			step(1);
			i++;
		end
		cmp(port_en, v);
	endtask
	task automatic pulse(input logic [1:0] sel);
		@(posedge clk);
		{paging_rx, rx_char} <= sel;
		@(posedge clk);
		{paging_rx, rx_char} <= 2'b00;
	endtask
	task automatic wake;
		while (busy) step(1);
		@(posedge clk);
		wake_req <= 1'b1;
		@(posedge clk);
		wake_req <= 1'b0;
		step(14);
	endtask
	// Write (w=1) or read (w=0) one register, checking the response, and the data on reads
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] er);
		logic ga, gw, gr, gd;
		logic [31:0] rd;
		logic [1:0] rs;
		gd = 1'b0;
		@(posedge clk);
		if (w)
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		else
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		while (!gd)
		begin
			@(negedge clk);
			ga = s_axi_awvalid && s_axi_awready;
			gw = s_axi_wvalid && s_axi_wready;
			gr = s_axi_arvalid && s_axi_arready;
			gd = w ? s_axi_bvalid : s_axi_rvalid;
			rs = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge clk);
			if (ga)
				s_axi_awvalid <= 1'b0;
			if (gw)
				s_axi_wvalid <= 1'b0;
			if (gr)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		cmp({30'h0, rs}, {30'h0, er});
		if (!w)
			cmp(rd, d);
	endtask
	initial
	begin
		{clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready, usb_active, tx_pending, rx_char, paging_rx,
			wake_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{sys_rst, port_init_done, rts_on, dtr_on} = 4'hf;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		step(2);
		cmp({cts_n, port_en, idle_ok, waking}, 4'b0100);
		acc(0, UPSC_OFS_CTRL, 32'h4, UPSC_RESP_OKAY);
		acc(0, UPSC_OFS_TMO, 32'h7d0, UPSC_RESP_OKAY);
		acc(1, 8'h10, 32'h1, UPSC_RESP_SLVERR);
		acc(0, 8'h10, 32'h0, UPSC_RESP_SLVERR);
		foreach (tv[i])
		begin
			acc(1, UPSC_OFS_TMO, tv[i], UPSC_RESP_OKAY);
			acc(0, UPSC_OFS_STAT, rv[i], UPSC_RESP_OKAY);
		end
		acc(0, UPSC_OFS_TMO, 32'h28, UPSC_RESP_OKAY);
		acc(1, UPSC_OFS_CTRL, 32'h6, UPSC_RESP_OKAY);
		acc(0, UPSC_OFS_STAT, 32'h13, UPSC_RESP_OKAY);
		acc(0, UPSC_OFS_CTRL, 32'h4, UPSC_RESP_OKAY);
		acc(1, UPSC_OFS_CTRL, 32'h5, UPSC_RESP_OKAY);
		step(1);
		cmp({cts_n, port_en, idle_ok}, 3'b101);
		@(posedge clk);
		tx_pending <= 1'b1;
		step(2);
		cmp({port_en, idle_ok}, 2'b10);
		tx_pending <= 1'b0;
		step(9580);
		cmp(port_en, 1'b0);
		wait_port(1'b1, 600);
		cmp(cts_n, 1'b0);
		pulse(2'b01);
		step(400);
		cmp(port_en, 1'b1);
		pulse(2'b01);
		step(700);
		cmp(port_en, 1'b1);
		wait_port(1'b0, 300);
		acc(1, UPSC_OFS_NET, 32'h1, UPSC_RESP_OKAY);
		acc(1, UPSC_OFS_CTRL, 32'h5, UPSC_RESP_OKAY);
		step(4000);
		pulse(2'b10);
		step(2);
		cmp(port_en, 1'b0);
		step(4100);
		pulse(2'b10);
		step(2);
		cmp(port_en, 1'b1);
		wait_port(1'b0, 120);
		acc(1, UPSC_OFS_NET, 32'h2, UPSC_RESP_OKAY);
		acc(1, UPSC_OFS_CTRL, 32'h5, UPSC_RESP_OKAY);
		step(9980);
		cmp(port_en, 1'b0);
		wait_port(1'b1, 60);
		cmp(cts_n, 1'b0);
		acc(1, UPSC_OFS_NET, 32'h0, UPSC_RESP_OKAY);
		acc(1, UPSC_OFS_CTRL, 32'h1, UPSC_RESP_OKAY);
		wake;
		cmp({port_en, waking}, 2'b01);
		wait_port(1'b1, 100);
		cmp(waking, 1'b0);
		wait_port(1'b0, 1000);
		acc(1, UPSC_OFS_CTRL, 32'h5, UPSC_RESP_OKAY);
		wake;
		cmp({port_en, waking}, 2'b00);
		acc(1, UPSC_OFS_CTRL, 32'h2, UPSC_RESP_OKAY);
		step(1);
		cmp({port_en, idle_ok}, 2'b10);
		rts_on <= 1'b0;
		step(2);
		cmp({port_en, idle_ok}, 2'b01);
		usb_active <= 1'b1;
		step(2);
		cmp({port_en, idle_ok}, 2'b00);
		usb_active <= 1'b0;
		step(2);
		rts_on <= 1'b1;
		step(2);
		cmp({port_en, waking}, 2'b11);
		step(90);
		cmp({port_en, waking}, 2'b10);
		acc(1, UPSC_OFS_CTRL, 32'h7, UPSC_RESP_OKAY);
		step(1);
		cmp({cts_n, port_en, idle_ok}, 3'b010);
		dtr_on <= 1'b0;
		step(2);
		cmp({cts_n, port_en, idle_ok}, 3'b101);
		cmp(dtr_ctrl, 1'b0);
		dtr_on <= 1'b1;
		step(2);
		cmp({port_en, waking}, 2'b11);
		step(90);
		cmp({cts_n, port_en, waking}, 3'b010);
		acc(1, UPSC_OFS_CTRL, 32'h4, UPSC_RESP_OKAY);
		port_init_done <= 1'b0;
		step(2);
		cmp({cts_n, port_en, idle_ok}, 3'b110);
		test_done;
	end
endmodule
bind upsc_top upsc_props #(.MS_CYCLES(MS_CYCLES)) u_props (.clk, .sys_rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .dtr_n, .usb_active, .tx_pending, .port_en, .idle_ok,
	.waking, .dtr_ctrl);

// [tb/upsc_host.sv]
`timescale 1ns/10ps
module upsc_host
	import upsc_pkg::*;
#(
	parameter int MS_CYCLES = UPSC_MS_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wake_req,
	input wire logic rts_on,
	input wire logic dtr_on,
	output logic host_txd,
	output logic rts_n,
	output logic dtr_n,
	output logic busy
);
	int cnt;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= 0;
		else if (wake_req && cnt == 0)
			cnt <= 21 * MS_CYCLES + 10;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// Start bit low for ten cycles, then idle high
	assign host_txd = !(cnt > 21 * MS_CYCLES);
	// No further character until the wake time is over
	assign busy = cnt != 0;
	assign rts_n = !rts_on;
	assign dtr_n = !dtr_on;
endmodule

// [tb/upsc_props.sv]
`timescale 1ns/10ps
module upsc_props
	import upsc_pkg::*;
#(
	parameter int MS_CYCLES = UPSC_MS_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic dtr_n,
	input wire logic usb_active,
	input wire logic tx_pending,
	input wire logic port_en,
	input wire logic idle_ok,
	input wire logic waking,
	input wire logic dtr_ctrl
);
	localparam int WLO = 19 * MS_CYCLES;
	localparam int WHI = 22 * MS_CYCLES;
	logic [31:0] wcnt_reg;
	logic [31:0] wcnt_next;
	// Length of the current wake period
	always_comb
		wcnt_next = waking ? wcnt_reg + 32'h1 : 32'h0;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			wcnt_reg <= 32'h0;
		else
			wcnt_reg <= wcnt_next;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	chk_tx_port: assert property (tx_pending |=> port_en)
		else $error("port off while own output pending");
	chk_tx_idle: assert property (tx_pending |=> !idle_ok)
		else $error("idle allowed while own output pending");
	chk_usb_idle: assert property (usb_active |=> !idle_ok)
		else $error("idle allowed while usb active");
	chk_idle_port: assert property (idle_ok |-> !port_en)
		else $error("idle allowed with port enabled");
	// A wake cut short by the line going off leaves the port off
	chk_wake_len: assert property ($fell(waking) && port_en |->
		wcnt_reg >= WLO && wcnt_reg <= WHI)
		else $error("wake period length wrong");
	chk_dtr_pass: assert property (!$past(sys_rst) |->
		dtr_ctrl == !$past(dtr_n))
		else $error("dtr level not passed through");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	cover property ($rose(waking));
	cover property ($rose(idle_ok));
	cover property (s_axi_bvalid && s_axi_bresp == UPSC_RESP_SLVERR);
endmodule
